/* src/hioc_pkg.sv */
// package: register map, fields and timing for the request output stage
package hioc_pkg;
  localparam logic [7:0]  OFS_IDENTITY   = 8'h50;
  localparam logic [7:0]  OFS_PIN_CFG    = 8'h54;
  localparam logic [7:0]  OFS_STATUS     = 8'h58;
  localparam logic [7:0]  OFS_ENABLE     = 8'h5c;
  localparam int          POS_INTERVAL   = 24;
  localparam int          POS_RESTART    = 14;
  localparam int          POS_ACTIVE     = 13;
  localparam int          POS_MASTER     = 12;
  localparam int          POS_OUT_EN     = 8;
  localparam int          POS_POLARITY   = 4;
  localparam int          POS_DRIVER     = 0;
  localparam int          POS_WAKE       = 17;
  localparam logic [31:0] RST_STATUS     = 32'h0000_0000;
  localparam logic [31:0] RST_ENABLE     = 32'h0000_0000;
  localparam logic [7:0]  RST_INTERVAL   = 8'h00;
  localparam logic [15:0] DEF_DEVICE_ID  = 16'h5a5a;
  localparam logic [15:0] DEF_REVISION   = 16'h0001;
  localparam int          CLK_MHZ        = 250;
  localparam int          STEP_US        = 10;
  localparam int          STEP_CYCLES    = STEP_US * CLK_MHZ;
  localparam logic [31:0] STATUS_RW1C    = 32'h83bb_e700;
  typedef enum logic [1:0] {
    HIOC_IDLE = 2'b00,
    HIOC_HOLD = 2'b01
  } hioc_state_e;
endpackage : hioc_pkg

/* src/hioc_tick.sv */
// ten microsecond step generator
`timescale 1ns/1ps
module hioc_tick #(
  parameter int STEP = hioc_pkg::STEP_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);
  import hioc_pkg::*;
  // sixteen-bit counter bounds the step length
  if (STEP < 2 || STEP > 65536)
  begin : g_step_check
    $error("step length out of range");
  end
  logic [15:0] count;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end
    else if (restart || count == 16'(STEP - 1))
    begin
      count <= 16'h0000;
      tick  <= !restart;
    end
    else
    begin
      count <= count + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule : hioc_tick

/* src/hioc_top.sv */
// request pin configuration, pending status, enable and identity registers
`timescale 1ns/1ps
// Notes on behaviour
// - eight-bit hold-off interval, ten microsecond steps
// - zero interval: disable, reset counter, release pending
// - new non-zero interval governs later interrupts
// - wake event bypasses hold-off entirely
// - restart bit clears counter, begins fresh interval
// - active bit reports hold-off, withholds pin
// - master bit shows internal line always
// - output enable clear keeps pin deasserted
// - polarity selects active level, survives soft reset
// - driver type open-drain or push-pull, survives
// - open-drain always active low, polarity ignored
// - identity register read-only, id and revision
// - writable registers decoded at 54h, 58h, 5ch
// - writing one clears pending bits set in STATUS_RW1C
// - survive-reset bits kept through soft reset
module hioc_top #(
  parameter logic [15:0] DEVICE_ID = hioc_pkg::DEF_DEVICE_ID,
  parameter logic [15:0] REVISION  = hioc_pkg::DEF_REVISION,
  parameter int          STEP      = hioc_pkg::STEP_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [31:0] event_set,
  output logic      [31:0] reg_rdata,
  output logic             req_out,
  output logic             req_oe_n
);
  import hioc_pkg::*;
  // identity values arbitrary
  logic [7:0]  interval;
  logic        out_en;
  logic        polarity;
  logic        driver_pp;
  logic [31:0] status;
  logic [31:0] enable;
  logic [7:0]  steps;
  logic        master;
  logic        gated;
  logic        asserted;
  logic        restart_req;
  logic        tick;
  logic        wr_cfg;
  logic        wr_sts;
  logic        wr_en;
  logic [31:0] pending;
  hioc_state_e state;

  assign wr_cfg  = reg_wr && reg_addr == OFS_PIN_CFG;
  assign wr_sts  = reg_wr && reg_addr == OFS_STATUS;
  assign wr_en   = reg_wr && reg_addr == OFS_ENABLE;
  assign pending = status & enable;
  assign master  = |pending;
  assign restart_req = wr_cfg && reg_wdata[POS_RESTART];

  // config fields with soft reset, except survivors
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      interval <= RST_INTERVAL;
      out_en   <= 1'b0;
    end
    else if (soft_rst)
    begin
      interval <= RST_INTERVAL;
      out_en   <= 1'b0;
    end
    else if (wr_cfg)
    begin
      interval <= reg_wdata[POS_INTERVAL +: 8];
      out_en   <= reg_wdata[POS_OUT_EN];
    end
  end

  // only a system reset clears these
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      polarity  <= 1'b0;
      driver_pp <= 1'b0;
    end
    else if (wr_cfg)
    begin
      polarity  <= reg_wdata[POS_POLARITY];
      driver_pp <= reg_wdata[POS_DRIVER];
    end
  end

  // set wins over write-one clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      status <= RST_STATUS;
    else if (soft_rst)
      status <= RST_STATUS | event_set;
    else if (wr_sts)
      status <= (status & ~(reg_wdata & STATUS_RW1C)) | event_set;
    else
      status <= status | event_set;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      enable <= RST_ENABLE;
    else if (soft_rst)
      enable <= RST_ENABLE;
    else if (wr_en)
      enable <= reg_wdata;
  end

  hioc_tick #(
    .STEP (STEP)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .restart (restart_req || state == HIOC_IDLE),
    .tick    (tick)
  );

  // hold-off sequencer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= HIOC_IDLE;
      steps <= 8'h00;
    end
    else if (soft_rst || (wr_cfg && reg_wdata[POS_INTERVAL +: 8] == 8'h00))
    begin
      state <= HIOC_IDLE;
      steps <= 8'h00;
    end
    else if (restart_req)
    begin
      state <= HIOC_HOLD;
      steps <= 8'h00;
    end
    else
    begin
      case (state)
        HIOC_IDLE:
        begin
          // falling request after acknowledge opens hold-off
          if (asserted && !gated && interval != 8'h00)
          begin
            state <= HIOC_HOLD;
            steps <= 8'h00;
          end
        end
        HIOC_HOLD:
        begin
          if (tick)
          begin
            if (steps + 8'h01 >= interval)
            begin
              state <= HIOC_IDLE;
              steps <= 8'h00;
            end
            else
              steps <= steps + 8'h01;
          end
        end
        default:
        begin
          state <= HIOC_IDLE;
          steps <= 8'h00;
        end
      endcase
    end
  end

  // wake source ignores hold-off
  always_comb
  begin
    gated = 1'b0;
    if (out_en)
      gated = (master && state != HIOC_HOLD) || pending[POS_WAKE];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      asserted <= 1'b0;
      req_out  <= 1'b1;
      req_oe_n <= 1'b1;
    end
    else
    begin
      asserted <= gated;
      if (!driver_pp)
      begin
        req_out  <= 1'b0;
        req_oe_n <= !gated;  // released pin floats high
      end
      else
      begin
        req_out  <= polarity ? gated : !gated;
        req_oe_n <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_IDENTITY: reg_rdata <= {DEVICE_ID, REVISION};
        OFS_PIN_CFG:  reg_rdata <= {interval, 10'h000, state == HIOC_HOLD, master,
                                    3'h0, out_en, 3'h0, polarity, 3'h0, driver_pp};
        OFS_STATUS:   reg_rdata <= status;
        OFS_ENABLE:   reg_rdata <= enable;
        default:      reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  property p_zero_releases;
    @(posedge clk_sys) disable iff (rst)
    (wr_cfg && reg_wdata[31:24] == 8'h00 && !restart_req) |=> state == HIOC_IDLE;
  endproperty
  a_zero_releases: assert property (p_zero_releases) else $error("zero interval kept hold");

  property p_restart;
    @(posedge clk_sys) disable iff (rst)
    (restart_req && !soft_rst && reg_wdata[31:24] != 8'h00) |=> state == HIOC_HOLD && steps == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missed");

  property p_disabled_pin;
    @(posedge clk_sys) disable iff (rst)
    !out_en |=> !asserted;
  endproperty
  a_disabled_pin: assert property (p_disabled_pin) else $error("pin asserted while disabled");

  property p_open_drain_low;
    @(posedge clk_sys) disable iff (rst)
    (!driver_pp && gated) |=> !req_out && !req_oe_n;
  endproperty
  a_open_drain_low: assert property (p_open_drain_low) else $error("open drain not low");

  property p_wake_bypass;
    @(posedge clk_sys) disable iff (rst)
    (out_en && pending[POS_WAKE]) |=> asserted;
  endproperty
  a_wake_bypass: assert property (p_wake_bypass) else $error("wake held off");

  property p_hold_withholds;
    @(posedge clk_sys) disable iff (rst)
    (state == HIOC_HOLD && !pending[POS_WAKE]) |=> !asserted;
  endproperty
  a_hold_withholds: assert property (p_hold_withholds) else $error("hold leaked");

  property p_survive;
    @(posedge clk_sys) disable iff (rst)
    (soft_rst && !wr_cfg) |=> polarity == $past(polarity) && driver_pp == $past(driver_pp);
  endproperty
  a_survive: assert property (p_survive) else $error("survivor bit lost");

  property p_clear_one;
    @(posedge clk_sys) disable iff (rst)
    (wr_sts && !soft_rst && reg_wdata[POS_WAKE] && !event_set[POS_WAKE]) |=> !status[POS_WAKE];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("write one did not clear");
endmodule : hioc_top

/* bench/hioc_host.sv */
// host processor model: register accesses over the parallel bus
`timescale 1ns/1ps
module hioc_host (
  input  wire logic        clk_sys,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  // callers keep reserved bits zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_wdata = ~d; // no stale data left on the bus
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd
endmodule : hioc_host

/* bench/tb_hioc_top.sv */
// testbench for the request output stage
`timescale 1ns/1ps
module tb_hioc_top;
  import hioc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        soft_rst = 1'b0;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] event_set = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic        req_out;
  logic        req_oe_n;
  int          fail_count = 0;
  int          num_checks = 0;
  // arbitrary identity values
  localparam logic [15:0] T_ID  = 16'h1234;
  localparam logic [15:0] T_REV = 16'h00ab;

  always #2 clk_sys = ~clk_sys;

  hioc_top #(.DEVICE_ID(T_ID), .REVISION(T_REV), .STEP(4)) i_hioc_top (
    .clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .event_set(event_set),
    .reg_rdata(reg_rdata), .req_out(req_out), .req_oe_n(req_oe_n));

  hioc_host i_hioc_host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  // reserved bits masked, their read value is not defined
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_hioc_host.rd(a, d);
    chk($sformatf("reg %h", a), e, (a == OFS_PIN_CFG) ? (d & 32'hff00_7111) : d);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic ev(input int b);
    @(negedge clk_sys);
    event_set = 32'h1 << b;
    @(negedge clk_sys);
    event_set = 32'h0000_0000;
    cyc(2);
  endtask : ev

  task automatic pin(input logic e);
    chk("req_out", {31'b0, e}, {31'b0, req_out});
  endtask : pin

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial
  begin
    #20000;
    fail_count++;
    results();
  end

  initial
  begin
    cyc(5);
    rst = 1'b0;
    rchk(OFS_IDENTITY, {T_ID, T_REV});
    i_hioc_host.wr(OFS_IDENTITY, 32'h0000_0000);
    rchk(OFS_IDENTITY, {T_ID, T_REV});
    rchk(8'h60, 32'h0000_0000);
    rchk(OFS_PIN_CFG, 32'h0000_0000);
    rchk(OFS_STATUS, 32'h0000_0000);
    rchk(OFS_ENABLE, 32'h0000_0000);
    $display("test registers done");
    i_hioc_host.wr(OFS_ENABLE, 32'h0002_0200);
    rchk(OFS_ENABLE, 32'h0002_0200);
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0000_0101);
    cyc(2);
    pin(1'b1);
    chk("req_oe_n", 32'h0, {31'b0, req_oe_n});
    ev(9);
    pin(1'b0);
    rchk(OFS_PIN_CFG, 32'h0000_1101);
    rchk(OFS_STATUS, 32'h0000_0200);
    i_hioc_host.wr(OFS_STATUS, 32'h0000_0200);
    cyc(2);
    pin(1'b1);
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0000_0110);
    ev(9);
    pin(1'b0);
    chk("req_oe_n", 32'h0, {31'b0, req_oe_n});
    i_hioc_host.wr(OFS_STATUS, 32'h0000_0200);
    cyc(2);
    chk("req_oe_n", 32'h1, {31'b0, req_oe_n});
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0000_0011);
    ev(9);
    pin(1'b0);
    rchk(OFS_PIN_CFG, 32'h0000_1011);
    i_hioc_host.wr(OFS_STATUS, 32'h0000_0200);
    $display("test pin modes done");
    // eight steps of four cycles: held about 32 cycles after release
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0800_0111);
    ev(9);
    pin(1'b1);
    i_hioc_host.wr(OFS_STATUS, 32'h0000_0200);
    cyc(2);
    pin(1'b0);
    rchk(OFS_PIN_CFG, 32'h0800_2111);
    ev(9);
    pin(1'b0);
    ev(17);
    pin(1'b1);
    i_hioc_host.wr(OFS_STATUS, 32'h0002_0000);
    cyc(2);
    pin(1'b0);
    cyc(16);
    pin(1'b0);
    cyc(4);
    pin(1'b1);
    // two steps now: the old length would still hold the pin
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0200_0111);
    i_hioc_host.wr(OFS_STATUS, 32'h0000_0200);
    ev(9);
    pin(1'b0);
    cyc(8);
    pin(1'b1);
    // restart mid-interval pushes delivery past the first end
    i_hioc_host.wr(OFS_STATUS, 32'h0000_0200);
    ev(9);
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0200_4111);
    rchk(OFS_PIN_CFG, 32'h0200_3111);
    cyc(3);
    pin(1'b0);
    cyc(6);
    pin(1'b1);
    i_hioc_host.wr(OFS_STATUS, 32'h0000_0200);
    ev(9);
    pin(1'b0);
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0000_0111);
    cyc(2);
    pin(1'b1);
    rchk(OFS_PIN_CFG, 32'h0000_1111);
    $display("test hold-off done");
    i_hioc_host.wr(OFS_PIN_CFG, 32'h0800_0111);
    ev(18);
    i_hioc_host.wr(OFS_STATUS, 32'h0004_0000);
    rchk(OFS_STATUS, 32'h0004_0200);
    @(negedge clk_sys);
    soft_rst = 1'b1;
    @(negedge clk_sys);
    soft_rst = 1'b0;
    rchk(OFS_PIN_CFG, 32'h0000_0011);
    rchk(OFS_STATUS, 32'h0000_0000);
    rchk(OFS_ENABLE, 32'h0000_0000);
    $display("test soft reset done");
    results();
  end
endmodule : tb_hioc_top
